// file: pcd_descriptor.sv
// Power-condition descriptor with its timer, reached over AXI4-Lite.
`timescale 1ns/10ps
module pcd_descriptor #(
  parameter int unsigned ADDR_W        = 8,
  parameter int unsigned TICK_CYCLES   = pcd_pkg::UNIT_CYCLES,
  parameter int unsigned SLOT          = 0,
  parameter logic        SUPPORTED     = 1'b1,
  parameter logic        SAVABLE       = 1'b1,
  parameter logic        CHANGEABLE    = 1'b1,
  parameter logic        DEFAULT_EN    = 1'b1,
  parameter logic [31:0] DEFAULT_TIMER = pcd_pkg::DEFAULT_TIMER,
  parameter logic [31:0] RECOVERY_TIME = pcd_pkg::RECOVERY_TIME,
  parameter logic [31:0] MIN_TIMER     = pcd_pkg::MIN_TIMER,
  parameter logic [31:0] MAX_TIMER     = pcd_pkg::MAX_TIMER
) (
  input  wire logic              mclk_in,
  input  wire logic              reset_n_in,
  input  wire logic              ce_in,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr_in,
  input  wire logic              s_axi_awvalid_in,
  output logic                   s_axi_awready_out,
  input  wire logic [31:0]       s_axi_wdata_in,
  input  wire logic [3:0]        s_axi_wstrb_in,
  input  wire logic              s_axi_wvalid_in,
  output logic                   s_axi_wready_out,
  output logic [1:0]             s_axi_bresp_out,
  output logic                   s_axi_bvalid_out,
  input  wire logic              s_axi_bready_in,
  input  wire logic [ADDR_W-1:0] s_axi_araddr_in,
  input  wire logic              s_axi_arvalid_in,
  output logic                   s_axi_arready_out,
  output logic [31:0]            s_axi_rdata_out,
  output logic [1:0]             s_axi_rresp_out,
  output logic                   s_axi_rvalid_out,
  input  wire logic              s_axi_rready_in,
  input  wire logic              command_done_in,
  output logic                   condition_entered_out,
  output logic                   timer_running_out
);

  // ==========================================================================
  // Parameter checks.
  // Registers up to 0x7C need seven bits.
  if (ADDR_W < 7 || ADDR_W > 16) begin : g_bad_addr
    $error("ADDR_W must lie between 7 and 16");
  end
  if (TICK_CYCLES < 1) begin : g_bad_tick
    $error("TICK_CYCLES must be at least one");
  end

  // ==========================================================================
  // Declarations.
  logic [ADDR_W-1:0]  aw_addr_q;
  logic               aw_hold_q;
  logic [31:0]        w_data_q;
  logic [3:0]         w_strb_q;
  logic               w_hold_q;
  logic               bvalid_q;
  logic [1:0]         bresp_q;
  logic               rvalid_q;
  logic [1:0]         rresp_q;
  logic [31:0]        rdata_q;
  logic               wr_go;
  logic [7:0]         wr_idx;
  logic               epc_q;
  logic               epc_prev_q;
  logic [31:0]        setval_q;
  logic [31:0]        saved_q;
  logic               saved_en_q;
  logic [31:0]        current_q;
  logic               current_en_q;
  logic               reject_q;
  logic               set_req;
  logic               set_ok;
  logic               restart;
  logic               run_ok;
  logic               sat;
  logic [31:0]        tick_q;
  logic [31:0]        units_q;
  pcd_pkg::pcd_state_t state_q;
  pcd_pkg::pcd_state_t state_d;
  pcd_pkg::pcd_flags_t flags;
  logic [31:0]        current_view;

  // ==========================================================================
  // Address decode shared by the read and write paths.
  function automatic logic [7:0] reg_idx(input logic [ADDR_W-1:0] addr);
    logic [15:0] wide;
    wide = 16'(addr);
    reg_idx = wide[9:2];
  endfunction

  function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
    logic [7:0] idx;
    idx = reg_idx(addr);
    is_mapped = (addr[1:0] == 2'h0) &&
                (idx == pcd_pkg::IDX_FLAGS ||
                 idx == pcd_pkg::IDX_DEFAULT ||
                 idx == pcd_pkg::IDX_SAVED ||
                 idx == pcd_pkg::IDX_CURRENT ||
                 idx == pcd_pkg::IDX_RECOVERY ||
                 idx == pcd_pkg::IDX_MIN ||
                 idx == pcd_pkg::IDX_MAX ||
                 idx == pcd_pkg::IDX_CTRL ||
                 idx == pcd_pkg::IDX_SETVAL ||
                 idx == pcd_pkg::IDX_STATUS ||
                 idx == pcd_pkg::IDX_LOGBASE);
  endfunction

  // ==========================================================================
  // Descriptor view.
  // Support masks every flag, so an
  // absent condition reads as zeros.
  always_comb begin
    flags            = '0;
    flags.supported  = SUPPORTED;
    flags.savable    = SUPPORTED & SAVABLE;
    flags.changeable = SUPPORTED & CHANGEABLE;
    flags.default_en = SUPPORTED & DEFAULT_EN;
    flags.saved_en   = SUPPORTED & saved_en_q;
    flags.current_en = SUPPORTED & epc_q & current_en_q;
    flags.rsvd       = 2'h0;
  end

  // Gating the readout rather than the stored value keeps current_q intact while hidden,
  // but switching the feature on again reloads it from saved_q.
  assign current_view = flags.current_en ? current_q : 32'h0000_0000;

  function automatic logic [31:0] read_word(input logic [7:0] idx);
    case (idx)
      pcd_pkg::IDX_FLAGS:    read_word = {24'h00_0000, flags};
      pcd_pkg::IDX_DEFAULT:  read_word = SUPPORTED ? DEFAULT_TIMER : 32'h0;
      pcd_pkg::IDX_SAVED:    read_word = SUPPORTED ? saved_q : 32'h0;
      pcd_pkg::IDX_CURRENT:  read_word = current_view;
      pcd_pkg::IDX_RECOVERY: read_word = RECOVERY_TIME;
      pcd_pkg::IDX_MIN:      read_word = MIN_TIMER;
      pcd_pkg::IDX_MAX:      read_word = MAX_TIMER;
      pcd_pkg::IDX_CTRL:     read_word = {31'h0, epc_q};
      pcd_pkg::IDX_SETVAL:   read_word = setval_q;
      pcd_pkg::IDX_STATUS:   read_word = {29'h0, condition_entered_out,
                                          timer_running_out, reject_q};
      pcd_pkg::IDX_LOGBASE:  read_word = 32'(SLOT * pcd_pkg::DESC_BYTES);
      default:               read_word = 32'h0000_0000;
    endcase
  endfunction

  // ==========================================================================
  // AXI4-Lite write channel.
  // Readies drop while an answer waits,
  // so one write at most is in flight.
  assign s_axi_awready_out = !aw_hold_q && !bvalid_q;
  assign s_axi_wready_out  = !w_hold_q && !bvalid_q;
  assign s_axi_bvalid_out  = bvalid_q;
  assign s_axi_bresp_out   = bresp_q;
  assign wr_go             = aw_hold_q && w_hold_q && !bvalid_q;
  assign wr_idx            = reg_idx(aw_addr_q);

  // Call only from clocked code: it reads
  // wr_go, which an assign would not see.
  function automatic logic wr_hit(input logic [7:0] idx);
    wr_hit = wr_go && (aw_addr_q[1:0] == 2'h0) && (wr_idx == idx);
  endfunction

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      aw_addr_q <= '0;
      aw_hold_q <= 1'b0;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
      w_hold_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= pcd_pkg::RESP_OKAY;
    end else if (ce_in) begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_addr_q <= s_axi_awaddr_in;
        aw_hold_q <= 1'b1;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_data_q <= s_axi_wdata_in;
        w_strb_q <= s_axi_wstrb_in;
        w_hold_q <= 1'b1;
      end
      if (wr_go) begin
        aw_hold_q <= 1'b0;
        w_hold_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        // Only the control registers take writes; the descriptor is read-only.
        if (wr_hit(pcd_pkg::IDX_CTRL) ||
            wr_hit(pcd_pkg::IDX_SETVAL) ||
            wr_hit(pcd_pkg::IDX_STATUS)) begin
          bresp_q <= pcd_pkg::RESP_OKAY;
        end else begin
          bresp_q <= pcd_pkg::RESP_SLVERR;
        end
      end else if (bvalid_q && s_axi_bready_in) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // AXI4-Lite read channel.
  // Read data is captured once and
  // holds until rready takes it.
  assign s_axi_arready_out = !rvalid_q;
  assign s_axi_rvalid_out  = rvalid_q;
  assign s_axi_rdata_out   = rdata_q;
  assign s_axi_rresp_out   = rresp_q;

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rvalid_q <= 1'b0;
      rresp_q  <= pcd_pkg::RESP_OKAY;
      rdata_q  <= 32'h0000_0000;
    end else if (ce_in) begin
      if (s_axi_arvalid_in && !rvalid_q) begin
        rvalid_q <= 1'b1;
        if (is_mapped(s_axi_araddr_in)) begin
          rresp_q <= pcd_pkg::RESP_OKAY;
          rdata_q <= read_word(reg_idx(s_axi_araddr_in));
        end else begin
          rresp_q <= pcd_pkg::RESP_SLVERR;
          rdata_q <= 32'h0000_0000;
        end
      end else if (rvalid_q && s_axi_rready_in) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Set-timer requests.
  // A zero value is accepted whenever epc_q is set on a changeable condition, because it is how software turns the
  // condition off; every other value must sit inside the reported limits, a limit of zero setting no bound.
  assign set_req = wr_go && (aw_addr_q[1:0] == 2'h0) && (wr_idx == pcd_pkg::IDX_CTRL) &&
                   w_strb_q[0] && w_data_q[pcd_pkg::CTRL_SET_BIT];
  assign set_ok  = SUPPORTED && CHANGEABLE && epc_q &&
                   ((setval_q == 32'h0) ||
                    (((MIN_TIMER == 32'h0) || (setval_q >= MIN_TIMER)) &&
                     ((MAX_TIMER == 32'h0) || (setval_q <= MAX_TIMER))));

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      epc_q      <= 1'b0;
      epc_prev_q <= 1'b0;
      setval_q   <= 32'h0000_0000;
    end else if (ce_in) begin
      epc_prev_q <= epc_q;
      if (wr_hit(pcd_pkg::IDX_CTRL) && w_strb_q[0]) begin
        epc_q <= w_data_q[pcd_pkg::CTRL_EPC_BIT];
      end
      // Strobes patch single bytes.
      if (wr_hit(pcd_pkg::IDX_SETVAL)) begin
        for (int b = 0; b < 4; b++) begin
          if (w_strb_q[b]) begin
            setval_q[8*b +: 8] <= w_data_q[8*b +: 8];
          end
        end
      end
    end
  end

  // Saved and current timers. Reset brings back the factory default.
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      saved_q      <= DEFAULT_TIMER;
      saved_en_q   <= DEFAULT_EN;
      current_q    <= DEFAULT_TIMER;
      current_en_q <= DEFAULT_EN;
    end else if (ce_in) begin
      if (set_req && set_ok) begin
        current_q    <= setval_q;
        current_en_q <= w_data_q[pcd_pkg::CTRL_EN_BIT];
        if (SAVABLE && w_data_q[pcd_pkg::CTRL_SAVE_BIT]) begin
          saved_q    <= setval_q;
          saved_en_q <= w_data_q[pcd_pkg::CTRL_EN_BIT];
        end
      end else if (epc_q && !epc_prev_q) begin
        // Enabling reloads the saved timer.
        current_q    <= saved_q;
        current_en_q <= saved_en_q;
      end
    end
  end

  // Rejection flag is sticky; a new rejection beats a clear in the same cycle.
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      reject_q <= 1'b0;
    end else if (ce_in) begin
      if (set_req && !set_ok) begin
        reject_q <= 1'b1;
      end else if (wr_hit(pcd_pkg::IDX_STATUS) && w_strb_q[0] &&
                   w_data_q[pcd_pkg::STAT_REJ_BIT]) begin
        reject_q <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Power-condition timer.
  // Support is fixed at build time, so an
  // absent condition never counts.
  assign run_ok  = epc_q && SUPPORTED && current_en_q && (current_q != 32'h0);
  assign sat     = (current_q == pcd_pkg::TIMER_SAT);
  assign restart = command_done_in || (set_req && set_ok);

  // Completions and accepted set-timers
  // send the timer back to counting.
  always_comb begin
    state_d = state_q;
    case (state_q)
      pcd_pkg::ST_OFF: begin
        if (run_ok) begin
          state_d = pcd_pkg::ST_COUNT;
        end
      end
      pcd_pkg::ST_COUNT: begin
        if (!run_ok) begin
          state_d = pcd_pkg::ST_OFF;
        end else if (!restart && !sat && (units_q >= current_q)) begin
          state_d = pcd_pkg::ST_ENTERED;
        end
      end
      pcd_pkg::ST_ENTERED: begin
        if (!run_ok) begin
          state_d = pcd_pkg::ST_OFF;
        end else if (restart) begin
          state_d = pcd_pkg::ST_COUNT;
        end
      end
      default: begin
        state_d = pcd_pkg::ST_OFF;
      end
    endcase
  end

  // The state freezes while ce_in is low.
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_q <= pcd_pkg::ST_OFF;
    end else if (ce_in) begin
      state_q <= state_d;
    end
  end

  // Units of 100 ms are counted from the last completion or accepted set-timer; the count saturates,
  // and the sat check in the state logic keeps an all-ones setting from ever expiring.
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tick_q  <= 32'h0000_0000;
      units_q <= 32'h0000_0000;
    end else if (ce_in) begin
      if (state_q != pcd_pkg::ST_COUNT || restart) begin
        tick_q  <= 32'h0000_0000;
        units_q <= 32'h0000_0000;
      end else if (tick_q == 32'(TICK_CYCLES - 1)) begin
        tick_q <= 32'h0000_0000;
        if (units_q != pcd_pkg::TIMER_SAT) begin
          units_q <= units_q + 32'h0000_0001;
        end
      end else begin
        tick_q <= tick_q + 32'h0000_0001;
      end
    end
  end

  // Outputs decode the one-hot state, so
  // they move only on a clock edge.
  assign condition_entered_out = (state_q == pcd_pkg::ST_ENTERED);
  assign timer_running_out     = (state_q == pcd_pkg::ST_COUNT);

endmodule

// file: pcd_pkg.sv
// Package with constants and types for the power-condition descriptor block.
// ==========================================================================
// Functional notes
// - Flag bit 7 reports condition supported
// - Flag bit 6 reports timer savable
// - Flag bit 5 reports timer changeable
// - Flag bit 4 reports default timer enabled
// - Flag bit 3 reports saved timer enabled
// - Current-enabled flag reads zero while feature disabled
// - Timer runs only when enabled, non-zero, flagged
// - Default timer fixed at manufacture, 100 units of 100 ms
// - Saved timer holds set value; zero disables
// - Wait current timer after completion before entering
// - Current timer reads zero when not active
// - All-ones timer means saturated, never expires
// - Recovery time field, zero means unspecified
// - Recovery time unchanged across every reset
// - Minimum limit reported and kept across resets
// - Maximum limit reported and kept across resets
// - Descriptor occupies its 64-byte log slot
package pcd_pkg;

  // ==========================================================================
  // Register indices; byte address is four times the index.
  localparam logic [7:0] IDX_FLAGS    = 8'h01;
  localparam logic [7:0] IDX_DEFAULT  = 8'h04;
  localparam logic [7:0] IDX_SAVED    = 8'h08;
  localparam logic [7:0] IDX_CURRENT  = 8'h0C;
  localparam logic [7:0] IDX_RECOVERY = 8'h10;
  localparam logic [7:0] IDX_MIN      = 8'h14;
  localparam logic [7:0] IDX_MAX      = 8'h18;
  localparam logic [7:0] IDX_CTRL     = 8'h1C;
  localparam logic [7:0] IDX_SETVAL   = 8'h1D;
  localparam logic [7:0] IDX_STATUS   = 8'h1E;
  localparam logic [7:0] IDX_LOGBASE  = 8'h1F;

  // ==========================================================================
  // Field positions.
  localparam int unsigned CTRL_EPC_BIT  = 0;
  localparam int unsigned CTRL_SET_BIT  = 1;
  localparam int unsigned CTRL_SAVE_BIT = 2;
  localparam int unsigned CTRL_EN_BIT   = 3;
  localparam int unsigned STAT_REJ_BIT  = 0;
  localparam int unsigned STAT_RUN_BIT  = 1;
  localparam int unsigned STAT_ENT_BIT  = 2;

  // ==========================================================================
  // Values, reset values and timing.
  localparam logic [31:0] TIMER_SAT       = 32'hFFFF_FFFF;
  localparam logic [31:0] DEFAULT_TIMER   = 32'h0000_0064;
  localparam logic [31:0] RECOVERY_TIME   = 32'h0000_0000;
  localparam logic [31:0] MIN_TIMER       = 32'h0000_0001;
  localparam logic [31:0] MAX_TIMER       = 32'h0000_8CA0;
  localparam int unsigned DESC_BYTES      = 64;
  localparam int unsigned CLK_HZ          = 25000000;
  localparam int unsigned TIMER_UNIT_MS   = 100;
  localparam int unsigned UNIT_CYCLES     = CLK_HZ / 1000 * TIMER_UNIT_MS;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  // ==========================================================================
  // Types.
  typedef struct packed {
    logic       supported;
    logic       savable;
    logic       changeable;
    logic       default_en;
    logic       saved_en;
    logic       current_en;
    logic [1:0] rsvd;
  } pcd_flags_t;

  typedef enum logic [2:0] {
    ST_OFF     = 3'h1,
    ST_COUNT   = 3'h2,
    ST_ENTERED = 3'h4
  } pcd_state_t;

endpackage

// file: pcd_descriptor_properties.sv
// Checker of handshake and timer relations at the descriptor ports.
`timescale 1ns/10ps
module pcd_descriptor_properties #(
  parameter int unsigned TICK_CYCLES = 4
) (
  input wire logic        mclk_in,
  input wire logic        reset_n_in,
  input wire logic        ce_in,
  input wire logic        s_axi_awready_out,
  input wire logic        s_axi_wready_out,
  input wire logic [1:0]  s_axi_bresp_out,
  input wire logic        s_axi_bvalid_out,
  input wire logic        s_axi_bready_in,
  input wire logic        s_axi_arvalid_in,
  input wire logic        s_axi_arready_out,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic [1:0]  s_axi_rresp_out,
  input wire logic        s_axi_rvalid_out,
  input wire logic        s_axi_rready_in,
  input wire logic        command_done_in,
  input wire logic        condition_entered_out,
  input wire logic        timer_running_out
);
  // ==========================================================================
  // Counting cycles since the last completion; a set-timer restart is not
  // visible here, so this is only an upper bound on the real wait.
  logic [31:0] run_cnt_q;
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      run_cnt_q <= 32'h0;
    end else if (ce_in) begin
      if (command_done_in || !timer_running_out) begin
        run_cnt_q <= 32'h0;
      end else begin
        run_cnt_q <= run_cnt_q + 32'h1;
      end
    end
  end

  // ==========================================================================
  // Properties.
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!reset_n_in);

  a_b_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in |=>
    s_axi_bvalid_out && $stable(s_axi_bresp_out)) else $error("Write answer dropped early.");
  a_r_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out &&
    $stable(s_axi_rdata_out) && $stable(s_axi_rresp_out)) else $error("Read answer changed.");
  a_read_lat: assert property (s_axi_arvalid_in && s_axi_arready_out && ce_in |=>
    s_axi_rvalid_out) else $error("Read answer late.");
  a_rd_done: assert property (s_axi_rvalid_out && s_axi_rready_in && ce_in |=>
    !s_axi_rvalid_out) else $error("Read answer not retired.");
  a_ar_ready: assert property (s_axi_arready_out == !s_axi_rvalid_out)
    else $error("Read address ready wrong.");
  a_wr_block: assert property (s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
    else $error("Write taken while answer pending.");
  a_slverr_zero: assert property (
    s_axi_rvalid_out && s_axi_rresp_out == pcd_pkg::RESP_SLVERR |-> s_axi_rdata_out == 32'h0)
    else $error("Error read returned data.");
  a_state_excl: assert property (!(condition_entered_out && timer_running_out))
    else $error("Entered while counting.");
  a_cmd_restart: assert property (
    condition_entered_out && command_done_in && ce_in |=> !condition_entered_out)
    else $error("Completion did not leave the condition.");
  a_min_wait: assert property ($rose(condition_entered_out) |-> run_cnt_q >= TICK_CYCLES)
    else $error("Condition entered too soon.");
endmodule

bind pcd_descriptor pcd_descriptor_properties #(.TICK_CYCLES(TICK_CYCLES)) u_props (
  .mclk_in(mclk_in), .reset_n_in(reset_n_in), .ce_in(ce_in),
  .s_axi_awready_out(s_axi_awready_out), .s_axi_wready_out(s_axi_wready_out),
  .s_axi_bresp_out(s_axi_bresp_out), .s_axi_bvalid_out(s_axi_bvalid_out),
  .s_axi_bready_in(s_axi_bready_in), .s_axi_arvalid_in(s_axi_arvalid_in),
  .s_axi_arready_out(s_axi_arready_out), .s_axi_rdata_out(s_axi_rdata_out),
  .s_axi_rresp_out(s_axi_rresp_out), .s_axi_rvalid_out(s_axi_rvalid_out),
  .s_axi_rready_in(s_axi_rready_in), .command_done_in(command_done_in),
  .condition_entered_out(condition_entered_out), .timer_running_out(timer_running_out));

// file: pcd_host_model.sv
// Host model: AXI4-Lite master issuing descriptor accesses and noting expected answers.
`timescale 1ns/10ps
module pcd_host_model (
  input  wire logic        clk_in,
  output logic [7:0]       awaddr_out,
  output logic             awvalid_out,
  input  wire logic        awready_in,
  output logic [31:0]      wdata_out,
  output logic             wvalid_out,
  input  wire logic        wready_in,
  input  wire logic        bvalid_in,
  output logic             bready_out,
  output logic [7:0]       araddr_out,
  output logic             arvalid_out,
  input  wire logic        arready_in,
  input  wire logic        rvalid_in,
  output logic             rready_out
);
  logic [33:0] rd_q[$];
  logic [1:0]  wr_q[$];

  initial begin
    awaddr_out = 8'h0;
    awvalid_out = 1'b0;
    wdata_out = 32'h0;
    wvalid_out = 1'b0;
    bready_out = 1'b0;
    araddr_out = 8'h0;
    arvalid_out = 1'b0;
    rready_out = 1'b0;
  end

  // ==========================================================================
  // Handshakes are judged half a cycle early, where they equal the edge sample.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic aw_t, w_t, b_t;
    @(posedge clk_in);
    wr_q.push_back(r);
    awaddr_out <= a;
    wdata_out <= d;
    awvalid_out <= 1'b1;
    wvalid_out <= 1'b1;
    bready_out <= 1'b1;
    forever begin
      @(negedge clk_in);
      aw_t = awvalid_out && awready_in;
      w_t = wvalid_out && wready_in;
      b_t = bvalid_in;
      @(posedge clk_in);
      if (aw_t) awvalid_out <= 1'b0;
      if (w_t) wvalid_out <= 1'b0;
      if (b_t) break;
    end
    bready_out <= 1'b0;
    wdata_out <= ~d;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic ar_t, r_t;
    @(posedge clk_in);
    rd_q.push_back({r, d});
    araddr_out <= a;
    arvalid_out <= 1'b1;
    rready_out <= 1'b1;
    forever begin
      @(negedge clk_in);
      ar_t = arvalid_out && arready_in;
      r_t = rvalid_in;
      @(posedge clk_in);
      if (ar_t) arvalid_out <= 1'b0;
      if (r_t) break;
    end
    rready_out <= 1'b0;
  endtask
endmodule

// file: pcd_descriptor_tb_top.sv
// Self-checking bench for the power-condition descriptor.
`timescale 1ns/10ps
module pcd_descriptor_tb_top;
  localparam logic [1:0]  OK  = pcd_pkg::RESP_OKAY;
  localparam logic [1:0]  ERR = pcd_pkg::RESP_SLVERR;
  localparam logic [31:0] REC = 32'h0000_0032;
  logic mclk_in, reset_n, cmd_done, entered, running, ce;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rnd, v;
  logic [1:0]  bresp, rresp, exp_b;
  logic [33:0] exp_r;
  int          bad_count, checks_done, cyc, n;

  pcd_descriptor #(.TICK_CYCLES(4), .SLOT(1), .RECOVERY_TIME(REC),
    .MIN_TIMER(32'h0000_0003), .MAX_TIMER(32'h0000_0000)) u_dut (
    .mclk_in(mclk_in), .reset_n_in(reset_n), .ce_in(ce),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .command_done_in(cmd_done),
    .condition_entered_out(entered), .timer_running_out(running));

  pcd_host_model u_host (
    .clk_in(mclk_in), .awaddr_out(awaddr), .awvalid_out(awvalid), .awready_in(awready),
    .wdata_out(wdata), .wvalid_out(wvalid), .wready_in(wready), .bvalid_in(bvalid),
    .bready_out(bready), .araddr_out(araddr), .arvalid_out(arvalid),
    .arready_in(arready), .rvalid_in(rvalid), .rready_out(rready));

  // ==========================================================================
  // Clock, checking and closing.
  initial begin
    mclk_in = 1'b0;
    forever #20 mclk_in = ~mclk_in;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    $display("Checks %0d, mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Answers are read at the edge before their own updates land.
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc > 6000) begin
      bad_count++;
      end_of_test();
    end
    if (rvalid && rready) begin
      exp_r = u_host.rd_q.pop_front();
      chk({30'h0, rresp}, {30'h0, exp_r[33:32]});
      chk(rdata, exp_r[31:0]);
    end
    if (bvalid && bready) begin
      exp_b = u_host.wr_q.pop_front();
      chk({30'h0, bresp}, {30'h0, exp_b});
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic kick;
    @(posedge mclk_in);
    cmd_done <= 1'b1;
    @(posedge mclk_in);
    cmd_done <= 1'b0;
  endtask

  task automatic do_reset;
    reset_n <= 1'b0;
    repeat (12) @(posedge mclk_in);
    reset_n <= 1'b1;
  endtask

  task automatic reg_table;
    u_host.rd(8'h04, 32'h0000_00F8, OK);
    u_host.rd(8'h10, 32'h0000_0064, OK);
    u_host.rd(8'h20, 32'h0000_0064, OK);
    u_host.rd(8'h30, 32'h0000_0000, OK);
    u_host.rd(8'h40, REC, OK);
    u_host.rd(8'h50, 32'h0000_0003, OK);
    u_host.rd(8'h60, 32'h0000_0000, OK);
    u_host.rd(8'h7C, 32'h0000_0040, OK);
    u_host.rd(8'h08, 32'h0000_0000, ERR);
  endtask

  // ==========================================================================
  // Main sequence.
  initial begin
    reset_n = 1'b0;
    cmd_done = 1'b0;
    ce = 1'b1;
    rnd = 32'h0000_0011;
    do_reset();
    u_host.wr(8'h10, 32'h1234_5678, ERR);
    reg_table();
    u_host.wr(8'h70, 32'h0000_0001, OK);
    u_host.rd(8'h04, 32'h0000_00FC, OK);
    u_host.rd(8'h30, 32'h0000_0064, OK);
    @(negedge mclk_in);
    chk({31'h0, running}, 32'h1);
    u_host.wr(8'h74, 32'h0000_0003, OK);
    u_host.wr(8'h70, 32'h0000_000F, OK);
    u_host.rd(8'h20, 32'h0000_0003, OK);
    u_host.rd(8'h30, 32'h0000_0003, OK);
    kick();
    ce <= 1'b0;
    repeat (8) @(posedge mclk_in);
    ce <= 1'b1;
    n = 0;
    do begin
      @(negedge mclk_in);
      n++;
    end while (entered !== 1'b1 && n < 40);
    chk(32'(n >= 12 && n <= 16), 32'h1);
    u_host.rd(8'h78, 32'h0000_0004, OK);
    u_host.wr(8'h74, 32'h0000_0002, OK);
    u_host.wr(8'h70, 32'h0000_000F, OK);
    u_host.rd(8'h78, 32'h0000_0005, OK);
    u_host.rd(8'h30, 32'h0000_0003, OK);
    kick();
    rnd = xs(rnd);
    v = 32'h0000_0003 + (rnd & 32'h0000_0FFF);
    u_host.wr(8'h74, v, OK);
    u_host.wr(8'h70, 32'h0000_000F, OK);
    u_host.rd(8'h30, v, OK);
    u_host.wr(8'h74, 32'hFFFF_FFFF, OK);
    u_host.wr(8'h70, 32'h0000_000F, OK);
    kick();
    repeat (60) @(negedge mclk_in);
    chk({31'h0, entered}, 32'h0);
    chk({31'h0, running}, 32'h1);
    u_host.wr(8'h74, 32'h0000_0005, OK);
    u_host.wr(8'h70, 32'h0000_0003, OK);
    u_host.rd(8'h04, 32'h0000_00F8, OK);
    u_host.rd(8'h30, 32'h0000_0000, OK);
    @(negedge mclk_in);
    chk({31'h0, running}, 32'h0);
    u_host.wr(8'h70, 32'h0000_0000, OK);
    u_host.rd(8'h04, 32'h0000_00F8, OK);
    u_host.rd(8'h20, 32'hFFFF_FFFF, OK);
    u_host.wr(8'h70, 32'h0000_0001, OK);
    @(posedge mclk_in);
    do_reset();
    reg_table();
    end_of_test();
  end
endmodule
